/* File: ts_pkg.sv */
// constants and register map for the timestamp input unit
package ts_pkg;
   // ==========================================================
   // bus widths
   localparam int ADDR_W = 11; // byte address width
   localparam int DATA_W = 16; // register width
   // ==========================================================
   // register offsets
   localparam logic [10:0] OFS_MASK = 11'h41A; // interrupt mask
   localparam logic [10:0] OFS_ISTAT = 11'h41C; // interrupt status, w1c
   localparam logic [10:0] OFS_CTRL = 11'h41E; // enable and ready
   localparam logic [10:0] OFS_STATUS = 11'h420; // count and overflow
   localparam logic [10:0] OFS_CFG = 11'h422; // timestamp_unit_config
   localparam logic [10:0] OFS_S1_NSL = 11'h424; // first_capture_ns_low
   localparam logic [10:0] OFS_S1_NSH = 11'h426; // first ns high and edge
   localparam logic [10:0] OFS_S1_SL = 11'h428; // first_capture_sec_low
   localparam logic [10:0] OFS_S1_SH = 11'h42A; // first_capture_sec_high
   localparam logic [10:0] OFS_S1_SUB = 11'h42C; // first_capture_subcycle
   localparam logic [10:0] OFS_S2_NSL = 11'h434; // second_capture_ns_low
   localparam logic [10:0] OFS_S2_NSH = 11'h436; // second ns high and edge
   localparam logic [10:0] OFS_S2_SL = 11'h438; // second seconds low
   localparam logic [10:0] OFS_S2_SH = 11'h43A; // second seconds high
   localparam logic [10:0] OFS_S2_SUB = 11'h43C; // second subcycle
   // ==========================================================
   // configuration fields
   localparam int CFG_PIN_LSB = 8; // pin select 11:8
   localparam int CFG_RISE = 7; // rising edge enable
   localparam int CFG_FALL = 6; // falling edge enable
   localparam int CFG_TAIL = 5; // tail of cascade
   localparam int CFG_UP_LSB = 1; // upstream select 4:1
   localparam int CFG_CASC = 0; // cascade enable
   localparam logic [11:0] CFG_WMASK = 12'hFFF; // writable bits
   localparam logic [15:0] CFG_RST = 16'h0000; // config after reset
   localparam logic [3:0] PIN_LAST = 4'h6; // highest valid pin code
   localparam int NUM_PINS = 7; // selectable pins
   localparam int NUM_UNITS = 12; // units in the chain
   localparam int EDGE_BIT = 14; // edge flag in ns high word
   // ==========================================================
   // control and interrupt fields
   localparam int CTRL_EN = 0; // capture_unit_enable
   localparam int CTRL_RDY = 1; // capture_unit_ready, read only
   localparam int IRQ_RDY = 0; // results available event
   localparam int IRQ_OVF = 1; // counter overflow event
   // ==========================================================
   // counts
   localparam logic [3:0] CNT_MAX = 4'hF; // event counter ceiling
   localparam logic [3:0] CASC_MAX = 4'h2; // events of a non-tail unit
   localparam int CYCLE_NS = 8; // core clock period
   localparam int SAMPLE_NS = 40; // sampling cycle period
   localparam int SUB_SLOTS = SAMPLE_NS / CYCLE_NS; // 8 ns slots per cycle
   localparam logic [2:0] SUB_LAST = 3'(SUB_SLOTS - 1); // last slot code
endpackage

/* File: ts_edge_detect.sv */
// edge detector for the selected timestamp input pin
`timescale 1ns/1ps
module ts_edge_detect (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic rise_en,
   input wire logic fall_en,
   output logic hit,
   output logic rising
);
   logic prev_q; // pin level one cycle back
   // ==========================================================
   // history
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= pin;
      end
   end
   // ==========================================================
   // qualified edges
   always_comb begin
      rising = pin & ~prev_q;
      hit = (rising & rise_en) | (~pin & prev_q & fall_en);
   end
endmodule // ts_edge_detect

/* File: ts_unit.sv */
// timestamp input unit: pin select, edge capture, cascade, registers
// ==========================================================
// Summary of operation
// (RULE1) config 11:8 picks pin 0 to 6
// (RULE2) config bit 7 enables rising edges
// (RULE3) config bit 6 enables falling edges
// (RULE4) config bit 5 marks cascade tail unit
// (RULE5) config 4:1 picks upstream done unit
// (RULE6) software numbers chain head 0, then predecessor
// (RULE7) config bit 0 joins cascade mode
// (RULE8) first capture ns low word readable
// (RULE9) first ns high holds bits 29:16
// (RULE10) ns high bit 14 shows edge direction
// (RULE11) first seconds read as two words
// (RULE12) subcycle code gives 8 ns slot
// (RULE13) second capture ns low word readable
// (RULE14) second ns high holds bits 29:16
// (RULE15) four-bit event counter saturates, flags overflow
// (RULE16) disable clears ready/overflow, enable clears count
// (RULE17) results set ready and interrupt
// (RULE18) first edge to slot one, next two
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module ts_unit (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ts_pkg::ADDR_W-1:0] addr,
   input wire logic [ts_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [ts_pkg::DATA_W-1:0] rdata,
   input wire logic [ts_pkg::NUM_PINS-1:0] gpio_in,
   input wire logic [31:0] rtc_sec,
   input wire logic [29:0] rtc_ns,
   input wire logic [ts_pkg::NUM_UNITS-1:0] upstream_done,
   output logic done_out,
   output logic irq
);
   import ts_pkg::*;

   // ==========================================================
   // state
   logic [15:0] cfg_q; // timestamp_unit_config
   logic en_q; // capture_unit_enable
   logic rdy_q; // capture_unit_ready
   logic ovf_q; // edge_counter_overflow
   logic [3:0] cnt_q; // edge_event_counter
   logic [1:0] istat_q; // sticky interrupt status
   logic [1:0] mask_q; // interrupt mask, bit 0 is capture_interrupt_enable
   logic [2:0] sub_q; // 8 ns slot within the 40 ns cycle
   logic done_q; // done toward downstream unit
   logic irq_q; // registered interrupt
   logic [15:0] rdata_q; // read data, one cycle after strobe
   // ==========================================================
   // derived
   logic [3:0] pin_sel; // pin select field
   logic [3:0] up_sel; // upstream select field
   logic pin_lvl; // selected pin level
   logic up_ok; // upstream permits capture
   logic hit; // qualified edge this cycle
   logic rising; // edge was rising
   logic take; // edge accepted by the unit
   logic limit; // count has reached its mode ceiling
   logic ovf_ok; // unit may flag overflow
   logic load1; // store into first slot
   logic load2; // store into second slot
   logic en_set; // enable written 0 to 1
   logic en_clr; // enable written 1 to 0
   logic ovf_ev; // overflow event
   logic [15:0] s1_nsl, s1_nsh, s1_sl, s1_sh, s1_sub; // first slot words
   logic [15:0] s2_nsl, s2_nsh, s2_sl, s2_sh, s2_sub; // second slot words

   // ==========================================================
   // 8 ns slot divider
   // five core cycles make one 40 ns sampling cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sub_q <= 3'h0;
      end else if (sub_q == SUB_LAST) begin
         sub_q <= 3'h0; // RULE12
      end else begin
         sub_q <= sub_q + 3'h1; // RULE12
      end
   end

   // ==========================================================
   // pin and upstream selection
   always_comb begin
      pin_sel = cfg_q[CFG_PIN_LSB +: 4];
      up_sel = cfg_q[CFG_UP_LSB +: 4];
      // unused pin codes watch nothing
      if (pin_sel <= PIN_LAST) begin
         pin_lvl = gpio_in[pin_sel[2:0]]; // RULE1
      end else begin
         pin_lvl = 1'b0; // RULE1
      end
      // head (code 0) or single mode needs no upstream done
      if (!cfg_q[CFG_CASC] || up_sel == 4'h0) begin
         up_ok = 1'b1; // RULE7
      end else if (up_sel <= 4'(NUM_UNITS)) begin
         up_ok = upstream_done[up_sel - 4'h1]; // RULE5 RULE6
      end else begin
         up_ok = 1'b0; // RULE5
      end
   end

   // edge detector on the selected pin
   ts_edge_detect u_edge (
      .core_clk(core_clk),
      .rst(rst),
      .pin(pin_lvl),
      .rise_en(cfg_q[CFG_RISE]),
      .fall_en(cfg_q[CFG_FALL]),
      .hit(hit),
      .rising(rising)
   );

   // ==========================================================
   // acceptance
   always_comb begin
      // a non-tail cascade member stops after two events
      if (cfg_q[CFG_CASC] && !cfg_q[CFG_TAIL]) begin
         limit = (cnt_q == CASC_MAX); // RULE4 RULE7
         ovf_ok = 1'b0; // RULE4
      end else begin
         limit = (cnt_q == CNT_MAX); // RULE15
         ovf_ok = 1'b1; // RULE15
      end
      take = en_q & up_ok & hit; // RULE2 RULE3
      load1 = take & (cnt_q == 4'h0); // RULE18
      load2 = take & (cnt_q == 4'h1); // RULE18
      ovf_ev = take & limit & ovf_ok; // RULE15
      en_set = wr & (addr == OFS_CTRL) & wdata[CTRL_EN] & ~en_q;
      en_clr = wr & (addr == OFS_CTRL) & ~wdata[CTRL_EN] & en_q;
   end

   // capture storage for the two events
   ts_capture_slot u_slot1 (
      .core_clk(core_clk),
      .rst(rst),
      .load(load1),
      .rising(rising),
      .sub(sub_q),
      .rtc_sec(rtc_sec),
      .rtc_ns(rtc_ns),
      .ns_low(s1_nsl),
      .ns_high(s1_nsh),
      .sec_low(s1_sl),
      .sec_high(s1_sh),
      .subcycle(s1_sub)
   );
   ts_capture_slot u_slot2 (
      .core_clk(core_clk),
      .rst(rst),
      .load(load2),
      .rising(rising),
      .sub(sub_q),
      .rtc_sec(rtc_sec),
      .rtc_ns(rtc_ns),
      .ns_low(s2_nsl),
      .ns_high(s2_nsh),
      .sec_low(s2_sl),
      .sec_high(s2_sh),
      .subcycle(s2_sub)
   );

   // ==========================================================
   // configuration register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= CFG_RST;
      end else if (wr && addr == OFS_CFG) begin
         // upper nibble is reserved and stays zero
         cfg_q <= {4'h0, wdata[11:0] & CFG_WMASK}; // RULE1 RULE4 RULE5
      end
   end

   // ==========================================================
   // enable and mask
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         en_q <= 1'b0;
         mask_q <= 2'h0;
      end else begin
         if (wr && addr == OFS_CTRL) begin
            en_q <= wdata[CTRL_EN];
         end
         if (wr && addr == OFS_MASK) begin
            mask_q <= wdata[1:0];
         end
      end
   end

   // ==========================================================
   // event counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
      end else if (en_set) begin
         cnt_q <= 4'h0; // RULE16
      end else if (take && !limit) begin
         cnt_q <= cnt_q + 4'h1; // RULE15
      end
   end

   // ==========================================================
   // ready and overflow flags
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdy_q <= 1'b0;
         ovf_q <= 1'b0;
      end else if (en_clr) begin
         rdy_q <= 1'b0; // RULE16
         ovf_q <= 1'b0; // RULE16
      end else begin
         if (load1) begin
            rdy_q <= 1'b1; // RULE17
         end
         if (ovf_ev) begin
            ovf_q <= 1'b1; // RULE15
         end
      end
   end

   // ==========================================================
   // done toward the next unit of the chain
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
      end else if (en_set || !en_q || !cfg_q[CFG_CASC]) begin
         done_q <= 1'b0;
      end else if (load2) begin
         done_q <= 1'b1; // RULE7
      end
   end

   // ==========================================================
   // sticky interrupt status, set wins over write-one-clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         istat_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == IRQ_RDY && load1) || (i == IRQ_OVF && ovf_ev)) begin
               istat_q[i] <= 1'b1; // RULE17
            end else if (wr && addr == OFS_ISTAT && wdata[i]) begin
               istat_q[i] <= 1'b0;
            end
         end
      end
   end

   // interrupt level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(istat_q & mask_q); // RULE17
      end
   end

   // ==========================================================
   // read data, one cycle after the strobe
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         unique case (addr)
            OFS_MASK: rdata_q <= {14'h0000, mask_q};
            OFS_ISTAT: rdata_q <= {14'h0000, istat_q};
            OFS_CTRL: rdata_q <= {14'h0000, rdy_q, en_q};
            OFS_STATUS: rdata_q <= {11'h000, cnt_q, ovf_q}; // RULE15
            OFS_CFG: rdata_q <= cfg_q;
            OFS_S1_NSL: rdata_q <= s1_nsl; // RULE8
            OFS_S1_NSH: rdata_q <= s1_nsh; // RULE9 RULE10
            OFS_S1_SL: rdata_q <= s1_sl; // RULE11
            OFS_S1_SH: rdata_q <= s1_sh; // RULE11
            OFS_S1_SUB: rdata_q <= s1_sub; // RULE12
            OFS_S2_NSL: rdata_q <= s2_nsl; // RULE13
            OFS_S2_NSH: rdata_q <= s2_nsh; // RULE14 RULE10
            OFS_S2_SL: rdata_q <= s2_sl;
            OFS_S2_SH: rdata_q <= s2_sh;
            OFS_S2_SUB: rdata_q <= s2_sub;
            // unmapped addresses read as zero
            default: rdata_q <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // outputs
   always_comb begin
      rdata = rdata_q;
      irq = irq_q;
      done_out = done_q;
   end
endmodule // ts_unit

/* File: ts_capture_slot.sv */
// one captured event: time, subcycle and edge direction
`timescale 1ns/1ps
module ts_capture_slot (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic rising,
   input wire logic [2:0] sub,
   input wire logic [31:0] rtc_sec,
   input wire logic [29:0] rtc_ns,
   output logic [15:0] ns_low,
   output logic [15:0] ns_high,
   output logic [15:0] sec_low,
   output logic [15:0] sec_high,
   output logic [15:0] subcycle
);
   logic [29:0] ns_q; // nanoseconds at 40 ns resolution
   logic [31:0] sec_q; // seconds
   logic [2:0] sub_q; // 8 ns slot code
   logic edge_q; // 1 rising, 0 falling
   // ==========================================================
   // storage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ns_q <= 30'h0;
         sec_q <= 32'h0;
         sub_q <= 3'h0;
         edge_q <= 1'b0;
      end else if (load) begin
         ns_q <= rtc_ns;
         sec_q <= rtc_sec;
         sub_q <= sub;
         edge_q <= rising;
      end
   end
   // ==========================================================
   // register words, reserved bits zero
   always_comb begin
      ns_low = ns_q[15:0];
      ns_high = {1'b0, edge_q, ns_q[29:16]};
      sec_low = sec_q[15:0];
      sec_high = sec_q[31:16];
      subcycle = {13'h0000, sub_q};
   end
endmodule // ts_capture_slot

/* File: ts_unit_assertions.sv */
// port assertions for the timestamp input unit
`timescale 1ns/1ps
module ts_unit_assertions
   import ts_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ts_pkg::ADDR_W-1:0] addr,
   input wire logic [ts_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [ts_pkg::DATA_W-1:0] rdata,
   input wire logic irq
);
   // ==========================================================
   // one clock domain, one reset
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_hold;
      !$past(rd) |-> $stable(rdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved without a read");
   property p_cfg;
      wr && addr == OFS_CFG ##1 !wr ##1 rd && addr == OFS_CFG
      |=> rdata == ($past(wdata, 3) & 16'h0FFF);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("config readback wrong");
   property p_nsh1;
      rd && addr == OFS_S1_NSH |=> !rdata[15];
   endproperty
   a_nsh1: assert property (p_nsh1)
      else $error("first ns high reserved bit set");
   property p_nsh2;
      rd && addr == OFS_S2_NSH |=> !rdata[15];
   endproperty
   a_nsh2: assert property (p_nsh2)
      else $error("second ns high reserved bit set");
   property p_sub;
      rd && (addr == OFS_S1_SUB || addr == OFS_S2_SUB)
      |=> rdata <= 16'h0004;
   endproperty
   a_sub: assert property (p_sub)
      else $error("subcycle code out of range");
   property p_dis;
      wr && addr == OFS_CTRL && !wdata[0] ##1 !wr ##1
      rd && addr == OFS_CTRL |=> rdata[1:0] == 2'b00;
   endproperty
   a_dis: assert property (p_dis)
      else $error("ready left set after disable");
   property p_stat;
      rd && addr == OFS_STATUS |=> rdata[15:5] == 11'h000 &&
      (!rdata[0] || rdata[4:1] == CNT_MAX);
   endproperty
   a_stat: assert property (p_stat)
      else $error("status word inconsistent");
   property p_mask;
      wr && addr == OFS_MASK && wdata[1:0] == 2'b00 ##1
      !(wr && addr == OFS_MASK) |=> !irq;
   endproperty
   a_mask: assert property (p_mask)
      else $error("interrupt high while masked");
endmodule // ts_unit_assertions
bind ts_unit ts_unit_assertions ts_unit_assertions_inst (
   .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .irq(irq)
);

/* File: ts_pin_source.sv */
// model of the external edge sources on the input pins
`timescale 1ns/1ps
module ts_pin_source (
   input wire logic core_clk,
   output logic [6:0] gpio_in
);
   // pins start low
   initial gpio_in = 7'h00;
   // one level change, at least one sampling cycle after the last
   task automatic drive(input int p, input logic lvl);
      repeat (5) @(posedge core_clk);
      gpio_in[p] <= lvl;
   endtask
endmodule // ts_pin_source

/* File: ts_unit_tb.sv */
// self-checking bench for the timestamp input unit
`timescale 1ns/1ps
module ts_unit_tb;
   import ts_pkg::*;
   // ==========================================================
   // design signals
   logic core_clk;
   logic rst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] rdata;
   logic [NUM_PINS-1:0] gpio_in;
   logic [31:0] rtc_sec;
   logic [29:0] rtc_ns;
   logic [NUM_UNITS-1:0] upstream_done;
   logic done_out;
   logic irq;
   logic [15:0] v; // last word read
   logic [15:0] s1; // first subcycle code
   int fails;
   int n_tests;
   ts_unit ts_unit_inst (
      .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .gpio_in(gpio_in),
      .rtc_sec(rtc_sec), .rtc_ns(rtc_ns), .upstream_done(upstream_done),
      .done_out(done_out), .irq(irq)
   );
   ts_pin_source ts_pin_source_inst (.core_clk(core_clk), .gpio_in(gpio_in));
   // ==========================================================
   // helpers
   task automatic check(input string nm, input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wrr(input logic [10:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [10:0] a);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rc(input logic [10:0] a, input logic [15:0] e);
      rdr(a);
      check($sformatf("reg %h", a), v, e);
   endtask
   task automatic tog(input int p);
      ts_pin_source_inst.drive(p, !gpio_in[p]);
      repeat (4) @(posedge core_clk);
   endtask
   task automatic restart(input logic [15:0] c);
      wrr(OFS_CTRL, 16'h0000);
      wrr(OFS_CFG, c);
      wrr(OFS_CTRL, 16'h0001);
   endtask
   task automatic final_report();
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      logic [10:0] r [12] = '{OFS_CFG, OFS_S1_NSL, OFS_S1_NSH, OFS_S1_SL,
         OFS_S1_SH, OFS_S1_SUB, OFS_S2_NSL, OFS_S2_NSH, OFS_STATUS,
         OFS_CTRL, OFS_ISTAT, 11'h430};
      foreach (r[i]) rc(r[i], 16'h0000);
   endtask
   task automatic t_cfg();
      logic [15:0] f [7] = '{16'h0F00, 16'h0600, 16'h0080, 16'h0040,
         16'h0020, 16'h001E, 16'h0001};
      foreach (f[i]) begin
         wrr(OFS_CFG, f[i] | 16'hF000);
         rc(OFS_CFG, f[i]);
      end
      wrr(OFS_S1_SH, 16'hFFFF);
      rc(OFS_S1_SH, 16'h0000);
   endtask
   task automatic t_capture();
      restart(16'h03C0);
      wrr(OFS_MASK, 16'h0001);
      rtc_sec <= 32'h12345678;
      rtc_ns <= 30'h2ABCDEF0;
      tog(2);
      tog(3);
      rtc_sec <= 32'h9ABC0011;
      rtc_ns <= 30'h15551234;
      tog(3);
      rc(OFS_S1_NSL, 16'hDEF0);
      rc(OFS_S1_NSH, 16'h6ABC);
      rc(OFS_S1_SL, 16'h5678);
      rc(OFS_S1_SH, 16'h1234);
      rc(OFS_S2_NSL, 16'h1234);
      rc(OFS_S2_NSH, 16'h1555);
      rc(OFS_S2_SL, 16'h0011);
      rc(OFS_S2_SH, 16'h9ABC);
      rc(OFS_STATUS, 16'h0004);
      rc(OFS_CTRL, 16'h0003);
      rdr(OFS_S1_SUB);
      s1 = v;
      rdr(OFS_S2_SUB);
      check("subcycle step", (v + 16'h0005 - s1) % 16'h0005,
         16'h0004);
      check("irq", 16'(irq), 16'h0001);
      check("done", 16'(done_out), 16'h0000);
   endtask
   task automatic t_irq();
      rc(OFS_ISTAT, 16'h0001);
      wrr(OFS_MASK, 16'h0000);
      @(posedge core_clk);
      #1 check("irq masked", 16'(irq), 16'h0000);
      wrr(OFS_MASK, 16'h0001);
      @(posedge core_clk);
      #1 check("irq unmasked", 16'(irq), 16'h0001);
      wrr(OFS_ISTAT, 16'h0001);
      @(posedge core_clk);
      #1 check("irq cleared", 16'(irq), 16'h0000);
   endtask
   task automatic t_edges();
      wrr(OFS_CTRL, 16'h0000);
      rc(OFS_CTRL, 16'h0000);
      rc(OFS_STATUS, 16'h0004);
      restart(16'h0380);
      rc(OFS_STATUS, 16'h0000);
      tog(3);
      tog(3);
      rc(OFS_STATUS, 16'h0002);
      rc(OFS_S1_NSH, 16'h5555);
      restart(16'h0340);
      tog(3);
      tog(3);
      rc(OFS_STATUS, 16'h0002);
      rc(OFS_S1_NSH, 16'h1555);
   endtask
   task automatic t_ovf();
      restart(16'h03C0);
      repeat (15) tog(3);
      rc(OFS_STATUS, 16'h001E);
      tog(3);
      rc(OFS_STATUS, 16'h001F);
      rc(OFS_ISTAT, 16'h0003);
      // overflow alone must raise the line through its own mask bit
      wrr(OFS_MASK, 16'h0002);
      rc(OFS_MASK, 16'h0002);
      wrr(OFS_ISTAT, 16'h0001);
      rc(OFS_ISTAT, 16'h0002);
      check("irq overflow", 16'(irq), 16'h0001);
      wrr(OFS_CTRL, 16'h0000);
      rc(OFS_STATUS, 16'h001E);
   endtask
   task automatic t_pin();
      for (int c = 0; c < 16; c++) begin
         restart(16'(c << 8) | 16'h00C0);
         for (int p = 0; p < NUM_PINS; p++)
            if (c >= NUM_PINS || p == c)
               tog(p);
         rc(OFS_STATUS, (c < NUM_PINS) ? 16'h0002 : 16'h0000);
      end
   endtask
   task automatic t_casc();
      restart(16'h03C1);
      repeat (4) tog(3);
      rc(OFS_STATUS, 16'h0004);
      check("done head", 16'(done_out), 16'h0001);
      restart(16'h03C5);
      tog(3);
      rc(OFS_STATUS, 16'h0000);
      upstream_done <= 12'h002;
      tog(3);
      rc(OFS_STATUS, 16'h0002);
      restart(16'h03E1);
      repeat (3) tog(3);
      rc(OFS_STATUS, 16'h0006);
      // upstream code beyond the last unit never lets an edge through
      upstream_done <= 12'hFFF;
      restart(16'h03DB);
      tog(3);
      rc(OFS_STATUS, 16'h0000);
   endtask
   // ==========================================================
   // clock, main sequence, watchdog
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      rst = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      rtc_sec = '0;
      rtc_ns = '0;
      upstream_done = '0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_cfg();
      t_capture();
      t_irq();
      t_edges();
      t_ovf();
      t_pin();
      t_casc();
      final_report();
   end
   initial begin
      repeat (50000) @(posedge core_clk);
      fails++;
      final_report();
   end
endmodule // ts_unit_tb
